// [ctaco_pkg.sv]
// Constants, types and register map of the clock/time arithmetic unit
package ctaco_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int METER_TICK_S   = 1;
  localparam int METER_TICK_CYC = CLK_HZ * METER_TICK_S;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPA0   = 8'h04;
  localparam logic [7:0] OFS_OPA1   = 8'h08;
  localparam logic [7:0] OFS_OPA2   = 8'h0C;
  localparam logic [7:0] OFS_OPB0   = 8'h10;
  localparam logic [7:0] OFS_OPB1   = 8'h14;
  localparam logic [7:0] OFS_OPB2   = 8'h18;
  localparam logic [7:0] OFS_RES0   = 8'h1C;
  localparam logic [7:0] OFS_RES1   = 8'h20;
  localparam logic [7:0] OFS_RES2   = 8'h24;
  localparam logic [7:0] OFS_FLAGS  = 8'h28;
  localparam logic [7:0] OFS_MHOUR  = 8'h2C;
  localparam logic [7:0] OFS_MSEC   = 8'h30;
  localparam logic [7:0] OFS_THRESH = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_MASK   = 8'h3C;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_REL_LSB = 4;
  localparam int CTRL_START   = 8;
  localparam int CTRL_MEN     = 9;
  localparam int CTRL_RETAIN  = 10;
  localparam int CTRL_RUN     = 11;
  localparam int FLG_ZERO     = 0;
  localparam int FLG_CARRY    = 1;
  localparam int FLG_BORROW   = 2;
  localparam int FLG_REL      = 3;
  localparam int FLG_ERR      = 4;
  localparam int EV_DONE      = 0;
  localparam int EV_ERR       = 1;
  localparam int EV_ALARM     = 2;
  localparam int EV_W         = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Limits and reset values
  localparam logic [15:0] HOUR_LIM      = 16'h0018;
  localparam logic [15:0] MINSEC_LIM    = 16'h003C;
  localparam logic [7:0]  MINSEC_LIM8   = 8'h3C;
  localparam logic [5:0]  HOUR_LIM6     = 6'h18;
  localparam logic [11:0] SEC_HOUR_LAST = 12'hE0F;
  localparam logic [15:0] METER_MAX     = 16'h7FFF;
  localparam logic [15:0] MONTH_MAX     = 16'h000C;
  localparam logic [15:0] LEAP_CENT     = 16'h0064;
  localparam logic [15:0] LEAP_QUAD     = 16'h0190;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] THRESH_RST    = 16'h7FFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    CTACO_TIME_SUM, CTACO_TIME_DIFF, CTACO_DATE_REL, CTACO_TIME_REL
  } ctaco_op_e;

  typedef enum logic [2:0] {
    CTACO_EQ, CTACO_LT, CTACO_GT, CTACO_NE, CTACO_GE, CTACO_LE
  } ctaco_rel_e;

  // Three words: hour/minute/second or year/month/day
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
  } ctaco_tri_s;

endpackage

// [ctaco_top.sv]
// Time arithmetic, time/date compare and run-hour meter with AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module ctaco_top #(
  parameter int unsigned TICKS_PER_SEC = ctaco_pkg::METER_TICK_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             ALARM_OUTPUT_BIT,
  output logic             IRQ
);
  import ctaco_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic addr_mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_MASK);
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic time_ok(ctaco_tri_s t);
    return (t.w0 < HOUR_LIM) && (t.w1 < MINSEC_LIM) && (t.w2 < MINSEC_LIM);
  endfunction

  function automatic logic date_ok(ctaco_tri_s d);
    logic       leap;
    logic [4:0] mdays;
    leap = (d.w0[1:0] == 2'h0) &&
           (((d.w0 % LEAP_CENT) != 16'h0000) ||
            ((d.w0 % LEAP_QUAD) == 16'h0000));
    case (d.w1)
      16'h0002: mdays = leap ? 5'h1D : 5'h1C;
      16'h0004, 16'h0006, 16'h0009, 16'h000B: mdays = 5'h1E;
      default: mdays = 5'h1F;
    endcase
    return (d.w1 >= 16'h0001) && (d.w1 <= MONTH_MAX) &&
           (d.w2 >= 16'h0001) && (d.w2 <= {11'h000, mdays});
  endfunction

  function automatic logic rel_hold(logic [2:0] rel, logic [47:0] a,
                                    logic [47:0] b);
    case (rel)
      CTACO_EQ: return a == b;
      CTACO_LT: return a < b;
      CTACO_GT: return a > b;
      CTACO_NE: return a != b;
      CTACO_GE: return a >= b;
      CTACO_LE: return a <= b;
      default:  return 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [31:0] rd_mux;

  wire logic do_write = aw_held && w_held && !bvalid;
  wire logic aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic w_take   = S_AXI_WVALID && S_AXI_WREADY;
  wire logic ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic wr_hit   = do_write && addr_mapped(aw_addr);

  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY  = !w_held && !bvalid;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [31:0]      ctrl;
  ctaco_tri_s       opa;
  ctaco_tri_s       opb;
  ctaco_tri_s       res;
  logic [4:0]       flags;
  logic [15:0]      thresh;
  logic [EV_W-1:0]  status;
  logic [EV_W-1:0]  mask;
  logic [15:0]      meter_hour;
  logic [11:0]      meter_sec;

  wire logic [31:0] wmerged = merge(ctrl, w_data, w_strb);
  wire logic [31:0] wlane   = merge(32'h0000_0000, w_data, w_strb);
  wire ctaco_op_e   op      = ctaco_op_e'(ctrl[CTRL_OP_LSB +: 2]);
  wire logic [2:0]  rel     = ctrl[CTRL_REL_LSB +: 3];
  wire logic        run     = ctrl[CTRL_RUN];
  wire logic        start   = wr_hit && (aw_addr == OFS_CTRL) &&
                              w_strb[1] && w_data[CTRL_START];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl <= CTRL_RST;
    end else if (wr_hit && aw_addr == OFS_CTRL) begin
      ctrl <= wmerged & ~(32'h1 << CTRL_START);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      opa    <= '0;
      opb    <= '0;
      thresh <= THRESH_RST;
      mask   <= '0;
    end else if (wr_hit) begin
      case (aw_addr)
        OFS_OPA0:   opa.w0 <= wlane[15:0];
        OFS_OPA1:   opa.w1 <= wlane[15:0];
        OFS_OPA2:   opa.w2 <= wlane[15:0];
        OFS_OPB0:   opb.w0 <= wlane[15:0];
        OFS_OPB1:   opb.w1 <= wlane[15:0];
        OFS_OPB2:   opb.w2 <= wlane[15:0];
        // Top bit dropped: threshold range 0..32767
        OFS_THRESH: thresh <= {1'b0, w_data[14:0]};
        OFS_MASK:   mask   <= w_data[EV_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time arithmetic
  wire logic [7:0] sec_sum  = {1'b0, opa.w2[6:0]} + {1'b0, opb.w2[6:0]};
  wire logic       c_sec    = sec_sum >= MINSEC_LIM8;
  wire logic [7:0] min_sum  = {1'b0, opa.w1[6:0]} + {1'b0, opb.w1[6:0]} +
                              {7'h00, c_sec};
  wire logic       c_min    = min_sum >= MINSEC_LIM8;
  wire logic [5:0] hour_sum = {1'b0, opa.w0[4:0]} + {1'b0, opb.w0[4:0]} +
                              {5'h00, c_min};
  wire logic       c_hour   = hour_sum >= HOUR_LIM6;

  wire logic [7:0] sec_dif  = {1'b0, opa.w2[6:0]} - {1'b0, opb.w2[6:0]};
  wire logic       b_sec    = sec_dif[7];
  wire logic [7:0] min_dif  = {1'b0, opa.w1[6:0]} - {1'b0, opb.w1[6:0]} -
                              {7'h00, b_sec};
  wire logic       b_min    = min_dif[7];
  wire logic [5:0] hour_dif = {1'b0, opa.w0[4:0]} - {1'b0, opb.w0[4:0]} -
                              {5'h00, b_min};
  wire logic       b_hour   = hour_dif[5];

  // Sum with carries seconds to minutes to hours
  wire ctaco_tri_s sum_res = '{
    w0: {10'h000, c_hour ? hour_sum - HOUR_LIM6 : hour_sum},
    w1: {8'h00, c_min ? min_sum - MINSEC_LIM8 : min_sum},
    w2: {8'h00, c_sec ? sec_sum - MINSEC_LIM8 : sec_sum}};
  // Difference with borrows, wrapping into the previous day
  wire ctaco_tri_s dif_res = '{
    w0: {10'h000, b_hour ? hour_dif + HOUR_LIM6 : hour_dif},
    w1: {8'h00, b_min ? min_dif + MINSEC_LIM8 : min_dif},
    w2: {8'h00, b_sec ? sec_dif + MINSEC_LIM8 : sec_dif}};

  wire logic       is_sum   = (op == CTACO_TIME_SUM);
  wire logic       is_date  = (op == CTACO_DATE_REL);
  wire logic       is_cmp   = (op == CTACO_DATE_REL) || (op == CTACO_TIME_REL);
  wire ctaco_tri_s arith    = is_sum ? sum_res : dif_res;
  wire logic       opd_ok   = is_date ? (date_ok(opa) && date_ok(opb))
                                      : (time_ok(opa) && time_ok(opb));
  wire logic       rel_now  = rel_hold(rel, opa, opb);

  // Invalid operands leave the result words untouched
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      res   <= '0;
      flags <= 5'h00;
    end else if (start && !opd_ok) begin
      flags[FLG_ERR] <= 1'b1;
    end else if (start && is_cmp) begin
      flags[FLG_REL] <= rel_now;
      flags[FLG_ERR] <= 1'b0;
    end else if (start) begin
      res               <= arith;
      flags[FLG_ZERO]   <= (arith == '0);
      flags[FLG_CARRY]  <= is_sum && c_hour;
      flags[FLG_BORROW] <= !is_sum && b_hour;
      flags[FLG_ERR]    <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Run-hour meter
  logic [31:0] presc;
  logic        run_prev;

  wire logic counting  = run && ctrl[CTRL_MEN];
  wire logic sec_tick  = counting && (presc == TICKS_PER_SEC - 1);
  wire logic hour_step = sec_tick && (meter_sec == SEC_HOUR_LAST);
  wire logic stop_clr  = run_prev && !run && !ctrl[CTRL_RETAIN];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      presc <= 32'h0000_0000;
    end else if (!counting || sec_tick) begin
      presc <= 32'h0000_0000;
    end else begin
      presc <= presc + 32'h0000_0001;
    end
  end

  // Alarm does not gate the count
  always_ff @(posedge CLK) begin
    if (!RST_N || stop_clr) begin
      meter_hour <= 16'h0000;
      meter_sec  <= 12'h000;
    end else if (hour_step) begin
      meter_sec  <= 12'h000;
      meter_hour <= (meter_hour == METER_MAX) ? 16'h0000
                                              : meter_hour + 16'h0001;
    end else if (sec_tick) begin
      meter_sec <= meter_sec + 12'h001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      run_prev         <= 1'b0;
      ALARM_OUTPUT_BIT <= 1'b0;
    end else begin
      run_prev         <= run;
      ALARM_OUTPUT_BIT <= meter_hour >= thresh;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  wire logic [EV_W-1:0] ev_set = {
    (meter_hour >= thresh) && !ALARM_OUTPUT_BIT,
    start && !opd_ok,
    start};
  wire logic [EV_W-1:0] ev_clr =
    (wr_hit && aw_addr == OFS_STATUS) ? w_data[EV_W-1:0] : '0;

  // Set wins over a simultaneous clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status <= '0;
      IRQ    <= 1'b0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
      IRQ    <= |(((status & ~ev_clr) | ev_set) & mask);
    end
  end

  always_comb begin
    case (S_AXI_ARADDR)
      OFS_CTRL:   rd_mux = ctrl;
      OFS_OPA0:   rd_mux = {16'h0000, opa.w0};
      OFS_OPA1:   rd_mux = {16'h0000, opa.w1};
      OFS_OPA2:   rd_mux = {16'h0000, opa.w2};
      OFS_OPB0:   rd_mux = {16'h0000, opb.w0};
      OFS_OPB1:   rd_mux = {16'h0000, opb.w1};
      OFS_OPB2:   rd_mux = {16'h0000, opb.w2};
      OFS_RES0:   rd_mux = {16'h0000, res.w0};
      OFS_RES1:   rd_mux = {16'h0000, res.w1};
      OFS_RES2:   rd_mux = {16'h0000, res.w2};
      OFS_FLAGS:  rd_mux = {27'h0000000, flags};
      OFS_MHOUR:  rd_mux = {16'h0000, meter_hour};
      OFS_MSEC:   rd_mux = {20'h00000, meter_sec};
      OFS_THRESH: rd_mux = {16'h0000, thresh};
      OFS_STATUS: rd_mux = {29'h00000000, status};
      OFS_MASK:   rd_mux = {29'h00000000, mask};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_good_arith;
    start && opd_ok && !is_cmp;
  endsequence
  sequence s_bad_start;
    start && !opd_ok;
  endsequence

  AST_ZERO_ONLY_MIDNIGHT: assert property (
    s_good_arith |=> flags[FLG_ZERO] == (res == '0))
    else $error("zero flag disagrees with result");
  AST_ERR_KEEPS_RESULT: assert property (
    s_bad_start |=> flags[FLG_ERR] && $stable(res) && status[EV_ERR])
    else $error("invalid operand produced a result");
  AST_SUM_CARRY: assert property (
    s_good_arith ##0 is_sum && hour_sum >= HOUR_LIM6 |=>
      flags[FLG_CARRY] && res.w0 < HOUR_LIM)
    else $error("day overflow without carry");
  AST_DIFF_BORROW: assert property (
    s_good_arith ##0 !is_sum |=> flags[FLG_BORROW] == $past(b_hour))
    else $error("borrow flag wrong");
  AST_ALARM_LEVEL: assert property (
    ##1 ALARM_OUTPUT_BIT == $past(meter_hour >= thresh))
    else $error("alarm level wrong");
  AST_HOUR_WRAP: assert property (
    hour_step && meter_hour == METER_MAX && !stop_clr |=> meter_hour == 0)
    else $error("hour count did not wrap to zero");
  AST_COUNT_AFTER_ALARM: assert property (
    ALARM_OUTPUT_BIT && hour_step && meter_hour < METER_MAX && !stop_clr
      |=> meter_hour == $past(meter_hour) + 16'h0001)
    else $error("meter froze under alarm");
  AST_STOP_CLEARS: assert property (
    run_prev && !run && !ctrl[CTRL_RETAIN] |=>
      meter_hour == 0 && meter_sec == 0)
    else $error("meter not cleared on stop");
  AST_REL_DEST: assert property (
    start && opd_ok && is_cmp |=> flags[FLG_REL] == $past(rel_now))
    else $error("relation bit wrong");
  AST_WRITE_RESP: assert property (
    do_write |=> S_AXI_BVALID ##0 !aw_held [*1])
    else $error("write response missing");

endmodule // ctaco_top

// [ctaco_tb.sv]
// Self-checking bench of the clock/time arithmetic unit
`timescale 1ns/1ns
module testbench;
  import ctaco_pkg::*;

  typedef struct {
    logic [1:0] op;
    logic [2:0] rel;
    ctaco_tri_s a;
    ctaco_tri_s b;
    ctaco_tri_s r;
    logic [4:0] fl;
    logic [4:0] mk;
  } ctaco_row_s;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        alarm;
  logic        irq;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  ctaco_row_s  rows[$];

  always #50 clk = ~clk;

  ctaco_top #(.TICKS_PER_SEC(4)) i_dut (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .ALARM_OUTPUT_BIT(alarm), .IRQ(irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Bus master: handshakes sampled at the rising edge that takes them
  task automatic bus_wr(input logic [7:0] adr, input logic [31:0] dat,
                        output logic [1:0] resp);
    logic aw_go;
    logic w_go;
    logic b_go;
    @(posedge clk);
    awaddr  <= adr;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      resp  = bresp;
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end while (!b_go);
    bready <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] adr, output logic [31:0] dat,
                        output logic [1:0] resp);
    logic ar_go;
    logic r_go;
    @(posedge clk);
    araddr  <= adr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      ar_go = arvalid && arready;
      r_go  = rvalid;
      dat   = rdata;
      resp  = rresp;
      if (ar_go) arvalid <= 1'b0;
    end while (!r_go);
    rready <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic add(input logic [1:0] op, input logic [2:0] rel,
    input ctaco_tri_s a, input ctaco_tri_s b, input ctaco_tri_s r,
    input logic [4:0] fl, input logic [4:0] mk);
    rows.push_back('{op, rel, a, b, r, fl, mk});
  endtask

  // Six relations in order EQ LT GT NE GE LE, hits[i] per relation
  task automatic add6(input logic [1:0] op, input ctaco_tri_s a,
                      input ctaco_tri_s b, input logic [5:0] hits);
    for (int i = 0; i < 6; i++) begin
      add(op, 3'(i), a, b, 48'h0, {1'b0, hits[i], 3'h0}, 5'h18);
    end
  endtask

  task automatic add_err(input logic [1:0] op, input ctaco_tri_s a,
                         input ctaco_tri_s b);
    add(op, 3'h0, a, b, 48'h0, 5'h10, 5'h10);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic [31:0] sec;
    logic [31:0] ctl;
    logic [1:0]  rs;
    int          n;
    add(2'h0, 3'h0, 48'h0017_003B_003B, 48'h0017_003A_003A,
        48'h0017_003A_0039, 5'h02, 5'h17);
    add(2'h0, 3'h0, 48'h0000_0000_0001, 48'h0017_003B_003B,
        48'h0000_0000_0000, 5'h03, 5'h17);
    add(2'h0, 3'h0, 48'h0000_003B_003B, 48'h0000_0000_0001,
        48'h0001_0000_0000, 5'h00, 5'h17);
    add(2'h0, 3'h0, 48'h0001_0002_0003, 48'h0004_0005_0006,
        48'h0005_0007_0009, 5'h00, 5'h17);
    add(2'h1, 3'h0, 48'h0017_003B_003A, 48'h0017_003B_003B,
        48'h0017_003B_003B, 5'h04, 5'h17);
    add(2'h1, 3'h0, 48'h0005_0000_0000, 48'h0005_0000_0000,
        48'h0000_0000_0000, 5'h01, 5'h17);
    add(2'h1, 3'h0, 48'h0003_0000_0000, 48'h0001_001E_001E,
        48'h0001_001D_001E, 5'h00, 5'h17);
    add6(2'h2, 48'h07D4_000A_0019, 48'h07D4_000A_0018, 6'h1C);
    add6(2'h2, 48'h07D4_0009_001E, 48'h07D4_000A_0001, 6'h2A);
    add6(2'h2, 48'h07D4_0002_001D, 48'h07D0_0002_001D, 6'h1C);
    add6(2'h3, 48'h0014_001E_003B, 48'h0014_001E_003B, 6'h31);
    add6(2'h3, 48'h0014_001E_003A, 48'h0014_001E_003B, 6'h2A);
    add6(2'h3, 48'h0017_0000_0000, 48'h0016_003B_003B, 6'h1C);
    add_err(2'h0, 48'h0018_0000_0000, 48'h0000_0000_0000);
    add_err(2'h1, 48'h0000_0000_0000, 48'h0000_003C_0000);
    add_err(2'h2, 48'h07D4_0009_001F, 48'h07D4_0001_0001);
    add_err(2'h2, 48'h07D3_0002_001D, 48'h07D4_0001_0001);
    add_err(2'h2, 48'h076C_0002_001D, 48'h07D4_0001_0001);
    add_err(2'h2, 48'h07D4_000D_0001, 48'h07D4_0001_0000);
    add_err(2'h3, 48'h0018_000A_001F, 48'h0000_0000_0000);
    add_err(2'h3, 48'h0000_0000_0000, 48'h000D_003B_003C);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      for (int k = 0; k < 3; k++) begin
        bus_wr(OFS_OPA0 + 8'(4 * k), {16'h0, rows[i].a[47 - 16 * k -: 16]}, rs);
        bus_wr(OFS_OPB0 + 8'(4 * k), {16'h0, rows[i].b[47 - 16 * k -: 16]}, rs);
      end
      ctl = {25'h0, rows[i].rel, 2'h0, rows[i].op};
      bus_wr(OFS_CTRL, ctl, rs);
      bus_wr(OFS_CTRL, ctl | 32'h0000_0100, rs);
      bus_rd(OFS_FLAGS, rd, rs);
      check(rd & {27'h0, rows[i].mk}, {27'h0, rows[i].fl});
      if (rows[i].op < 2'h2 && rows[i].mk != 5'h10) begin
        for (int k = 0; k < 3; k++) begin
          bus_rd(OFS_RES0 + 8'(4 * k), rd, rs);
          check(rd, {16'h0, rows[i].r[47 - 16 * k -: 16]});
        end
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Interrupt raise, mask and clear
    bus_wr(OFS_MASK, 32'h0000_0001, rs);
    repeat (2) @(negedge clk);
    check(irq, 1'b1);
    bus_rd(OFS_STATUS, rd, rs);
    check(rd, 32'h0000_0003);
    bus_wr(OFS_STATUS, 32'h0000_0007, rs);
    bus_rd(OFS_STATUS, rd, rs);
    check(rd, 32'h0000_0000);
    check(irq, 1'b0);
    // Unmapped and unaligned places
    bus_wr(8'h40, 32'h0000_0001, rs);
    check(rs, RESP_SLVERR);
    bus_rd(8'h05, rd, rs);
    check({rs, rd}, {RESP_SLVERR, 32'h0000_0000});
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({awready, wready, arready, bvalid, rvalid, irq, alarm}, 7'h70);
    bus_rd(OFS_CTRL, rd, rs);
    check(rd, CTRL_RST);
    bus_rd(OFS_THRESH, rd, rs);
    check(rd, {16'h0, THRESH_RST});
    bus_wr(OFS_THRESH, 32'h0000_8001, rs);
    bus_rd(OFS_THRESH, rd, rs);
    check(rd, 32'h0000_0001);
    // Run-hour meter up to the alarm
    bus_wr(OFS_MASK, 32'h0000_0004, rs);
    bus_wr(OFS_CTRL, 32'h0000_0A00, rs);
    n = 0;
    while (alarm !== 1'b1 && n < 16000) begin
      @(negedge clk);
      n++;
    end
    check(alarm, 1'b1);
    check(irq, 1'b1);
    bus_rd(OFS_MHOUR, rd, rs);
    check(rd, 32'h0000_0001);
    bus_rd(OFS_MSEC, sec, rs);
    repeat (20) @(negedge clk);
    bus_rd(OFS_MSEC, rd, rs);
    check(rd > sec, 1'b1);
    // Retentive stop keeps the count, plain stop clears it
    bus_wr(OFS_CTRL, 32'h0000_0E00, rs);
    bus_wr(OFS_CTRL, 32'h0000_0600, rs);
    bus_rd(OFS_MHOUR, rd, rs);
    check(rd, 32'h0000_0001);
    bus_wr(OFS_CTRL, 32'h0000_0A00, rs);
    bus_wr(OFS_CTRL, 32'h0000_0200, rs);
    bus_rd(OFS_MHOUR, rd, rs);
    check(rd, 32'h0000_0000);
    bus_rd(OFS_MSEC, rd, rs);
    check(rd, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check(alarm, 1'b0);
    final_report();
  end
endmodule // testbench
